// ---- rtl/dbw_unit.sv ----
/*
  debug breakpoint and watchpoint unit: registers, match units, cause capture.
  assumes core pipeline inputs are on ref_clk and the debugger uses the
  plain register port with read data one cycle after the read strobe.
*/
// Decided for this implementation: the plain strobed port.
//
// Function
// - four instruction breakpoints with 32-bit address; enabled match raises debug interrupt unless debug_mode is set
// - each instruction breakpoint has its own address and control register
// - every control register has 8-bit per-thread enable, reset zero
// - instruction control bit 1: clear breaks on equal, set on not equal
// - control bit 0 enables the unit; cleared at reset, never fires
// - four data watchpoints, each with readable and writable first address
// - each data watchpoint has a second address used in its condition
// - each data watchpoint has its own control register
// - data control bit 2 set makes the watchpoint fire on loads
// - data control bit 1: clear needs A and B, set A or B
// - four resource watchpoints, each with a 32-bit identifier mask
// - each resource watchpoint has a 32-bit value to compare against
// - each resource watchpoint has its own control register
// - resource control bit 1: clear fires on A, set on not A
// - cause code recorded: 3 instruction, 4 data, 5 resource
// - thread number of the cause recorded in eight bits
// - data hit captures effective address, resource hit the identifier
`timescale 1ns/1ps
`default_nettype none
module dbw_unit
  import dbw_pkg::*;
#(
  parameter int unsigned UNITS = DBW_UNITS
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [2:0] issue_thread,
  input wire logic issue_valid,
  input wire logic [31:0] issue_pc,
  input wire logic mem_valid,
  input wire logic mem_load,
  input wire logic [31:0] mem_addr,
  input wire logic res_valid,
  input wire logic [31:0] res_id,
  input wire logic debug_mode,
  output logic debug_irq
);
  if (UNITS < 1 || UNITS > DBW_UNITS) begin : g_bad_units
    $error("dbw_unit: UNITS must be 1 to 4");
  end

  logic [UNITS-1:0][31:0] iba_q;
  logic [UNITS-1:0][31:0] iba_d;
  logic [UNITS-1:0][31:0] ibc_q;
  logic [UNITS-1:0][31:0] ibc_d;
  logic [UNITS-1:0][31:0] dwa1_q;
  logic [UNITS-1:0][31:0] dwa1_d;
  logic [UNITS-1:0][31:0] dwa2_q;
  logic [UNITS-1:0][31:0] dwa2_d;
  logic [UNITS-1:0][31:0] dwc_q;
  logic [UNITS-1:0][31:0] dwc_d;
  logic [UNITS-1:0][31:0] rwm_q;
  logic [UNITS-1:0][31:0] rwm_d;
  logic [UNITS-1:0][31:0] rwv_q;
  logic [UNITS-1:0][31:0] rwv_d;
  logic [UNITS-1:0][31:0] rwc_q;
  logic [UNITS-1:0][31:0] rwc_d;
  logic [31:0] type_q;
  logic [31:0] type_d;
  logic [31:0] data_q;
  logic [31:0] data_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic irq_q;
  logic irq_d;

  logic [UNITS-1:0] ib_hit;
  logic [UNITS-1:0] dw_hit;
  logic [UNITS-1:0] rw_hit;
  logic any_hit;
  dbw_cause_type cause;
  logic [1:0] hit_index;
  logic take;

  dbw_core_if core_bus ();

  assign core_bus.thread = issue_thread;
  assign core_bus.pc_valid = issue_valid;
  assign core_bus.pc = issue_pc;
  assign core_bus.ea_valid = mem_valid;
  assign core_bus.ea_load = mem_load;
  assign core_bus.ea = mem_addr;
  assign core_bus.rid_valid = res_valid;
  assign core_bus.rid = res_id;

  // per-unit comparators, all evaluated every cycle
  for (genvar g = 0; g < UNITS; g++) begin : g_unit
    dbw_match #(.KIND(DBW_KIND_INSTR)) u_ib (
      .op(core_bus.sink),
      .ctl(ibc_q[g]),
      .opa(iba_q[g]),
      .opb(32'h00000000),
      .hit(ib_hit[g])
    );
    dbw_match #(.KIND(DBW_KIND_DATA)) u_dw (
      .op(core_bus.sink),
      .ctl(dwc_q[g]),
      .opa(dwa1_q[g]),
      .opb(dwa2_q[g]),
      .hit(dw_hit[g])
    );
    dbw_match #(.KIND(DBW_KIND_RES)) u_rw (
      .op(core_bus.sink),
      .ctl(rwc_q[g]),
      .opa(rwm_q[g]),
      .opb(rwv_q[g]),
      .hit(rw_hit[g])
    );
  end

  dbw_cause #(.UNITS(UNITS)) u_cause (
    .ib_hit(ib_hit),
    .dw_hit(dw_hit),
    .rw_hit(rw_hit),
    .any_hit(any_hit),
    .cause(cause),
    .index(hit_index)
  );

  // no new interrupt while the debugger already holds the machine
  assign take = any_hit && !debug_mode;

  // per-unit index decode of the register port
  logic [UNITS-1:0] iba_sel;
  logic [UNITS-1:0] ibc_sel;
  logic [UNITS-1:0] dwa1_sel;
  logic [UNITS-1:0] dwa2_sel;
  logic [UNITS-1:0] dwc_sel;
  logic [UNITS-1:0] rwm_sel;
  logic [UNITS-1:0] rwv_sel;
  logic [UNITS-1:0] rwc_sel;

  for (genvar g = 0; g < UNITS; g++) begin : g_sel
    assign iba_sel[g] = (reg_addr == DBW_IBA_IDX + 8'(g));
    assign ibc_sel[g] = (reg_addr == DBW_IBC_IDX + 8'(g));
    assign dwa1_sel[g] = (reg_addr == DBW_DWA1_IDX + 8'(g));
    assign dwa2_sel[g] = (reg_addr == DBW_DWA2_IDX + 8'(g));
    assign dwc_sel[g] = (reg_addr == DBW_DWC_IDX + 8'(g));
    assign rwm_sel[g] = (reg_addr == DBW_RWM_IDX + 8'(g));
    assign rwv_sel[g] = (reg_addr == DBW_RWV_IDX + 8'(g));
    assign rwc_sel[g] = (reg_addr == DBW_RWC_IDX + 8'(g));
  end

  // instruction breakpoint registers
  always_comb begin
    iba_d = iba_q;
    ibc_d = ibc_q;
    if (reg_wr) begin
      for (int i = 0; i < UNITS; i++) begin
        if (iba_sel[i]) begin
          iba_d[i] = reg_wdata;
        end
        if (ibc_sel[i]) begin
          ibc_d[i] = reg_wdata & DBW_IBC_WMASK;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < UNITS; i++) begin
        iba_q[i] <= DBW_ADDR_RST;
        ibc_q[i] <= DBW_CTL_RST;
      end
    end else begin
      iba_q <= iba_d;
      ibc_q <= ibc_d;
    end
  end

  // data watchpoint registers
  always_comb begin
    dwa1_d = dwa1_q;
    dwa2_d = dwa2_q;
    dwc_d = dwc_q;
    if (reg_wr) begin
      for (int i = 0; i < UNITS; i++) begin
        if (dwa1_sel[i]) begin
          dwa1_d[i] = reg_wdata;
        end
        if (dwa2_sel[i]) begin
          dwa2_d[i] = reg_wdata;
        end
        if (dwc_sel[i]) begin
          dwc_d[i] = reg_wdata & DBW_DWC_WMASK;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < UNITS; i++) begin
        dwa1_q[i] <= DBW_ADDR_RST;
        dwa2_q[i] <= DBW_ADDR_RST;
        dwc_q[i] <= DBW_CTL_RST;
      end
    end else begin
      dwa1_q <= dwa1_d;
      dwa2_q <= dwa2_d;
      dwc_q <= dwc_d;
    end
  end

  // resource watchpoint registers
  always_comb begin
    rwm_d = rwm_q;
    rwv_d = rwv_q;
    rwc_d = rwc_q;
    if (reg_wr) begin
      for (int i = 0; i < UNITS; i++) begin
        if (rwm_sel[i]) begin
          rwm_d[i] = reg_wdata;
        end
        if (rwv_sel[i]) begin
          rwv_d[i] = reg_wdata;
        end
        if (rwc_sel[i]) begin
          rwc_d[i] = reg_wdata & DBW_RWC_WMASK;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      for (int i = 0; i < UNITS; i++) begin
        rwm_q[i] <= DBW_ADDR_RST;
        rwv_q[i] <= DBW_ADDR_RST;
        rwc_q[i] <= DBW_CTL_RST;
      end
    end else begin
      rwm_q <= rwm_d;
      rwv_q <= rwv_d;
      rwc_q <= rwc_d;
    end
  end

  // capture registers; a hit beats a same-cycle debugger write, except that an instruction hit lets a data register write stand
  always_comb begin
    type_d = type_q;
    data_d = data_q;
    irq_d = 1'b0;
    if (reg_wr && reg_addr == DBW_IRQ_TYPE_IDX) begin
      type_d = reg_wdata & DBW_TYPE_WMASK;
    end
    if (reg_wr && reg_addr == DBW_IRQ_DATA_IDX) begin
      data_d = reg_wdata;
    end
    if (take) begin
      irq_d = 1'b1;
      type_d = 32'h00000000;
      type_d[DBW_TYPE_CAUSE_LSB +: 3] = cause;
      type_d[DBW_TYPE_IDX_LSB +: 2] = hit_index;
      type_d[DBW_TYPE_THR_LSB +: 8] = {5'h00, issue_thread};
      if (cause == DBW_CAUSE_DATA) begin
        data_d = mem_addr;
      end else if (cause == DBW_CAUSE_RES) begin
        data_d = res_id;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      type_q <= DBW_TYPE_RST;
      data_q <= DBW_ADDR_RST;
      irq_q <= 1'b0;
    end else begin
      type_q <= type_d;
      data_q <= data_d;
      irq_q <= irq_d;
    end
  end

  // read decode; unmapped indexes read zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (reg_rd) begin
      for (int i = 0; i < UNITS; i++) begin
        if (iba_sel[i]) begin
          rdata_d = iba_q[i];
        end
        if (ibc_sel[i]) begin
          rdata_d = ibc_q[i];
        end
        if (dwa1_sel[i]) begin
          rdata_d = dwa1_q[i];
        end
        if (dwa2_sel[i]) begin
          rdata_d = dwa2_q[i];
        end
        if (dwc_sel[i]) begin
          rdata_d = dwc_q[i];
        end
        if (rwm_sel[i]) begin
          rdata_d = rwm_q[i];
        end
        if (rwv_sel[i]) begin
          rdata_d = rwv_q[i];
        end
        if (rwc_sel[i]) begin
          rdata_d = rwc_q[i];
        end
      end
      if (reg_addr == DBW_IRQ_TYPE_IDX) begin
        rdata_d = type_q;
      end
      if (reg_addr == DBW_IRQ_DATA_IDX) begin
        rdata_d = data_q;
      end
    end
  end

  // read data stand for the one cycle after the strobe only
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 32'h00000000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign debug_irq = irq_q;
endmodule
`default_nettype wire

// ---- rtl/dbw_pkg.sv ----
/*
  shared constants and types of the breakpoint and watchpoint unit.
  assumes an 8-bit register index bus and eight logical cores.
*/
package dbw_pkg;
  localparam int unsigned DBW_ADDR_W = 8;
  localparam int unsigned DBW_DATA_W = 32;
  localparam int unsigned DBW_UNITS = 4;
  localparam int unsigned DBW_THREADS = 8;
  localparam int unsigned DBW_THREAD_W = 3;

  // register indexes
  localparam logic [7:0] DBW_IRQ_TYPE_IDX = 8'h15;
  localparam logic [7:0] DBW_IRQ_DATA_IDX = 8'h16;
  localparam logic [7:0] DBW_IBA_IDX = 8'h30;
  localparam logic [7:0] DBW_IBC_IDX = 8'h40;
  localparam logic [7:0] DBW_DWA1_IDX = 8'h50;
  localparam logic [7:0] DBW_DWA2_IDX = 8'h60;
  localparam logic [7:0] DBW_DWC_IDX = 8'h70;
  localparam logic [7:0] DBW_RWM_IDX = 8'h80;
  localparam logic [7:0] DBW_RWV_IDX = 8'h90;
  localparam logic [7:0] DBW_RWC_IDX = 8'h9C;

  // control register fields
  localparam int unsigned DBW_CTL_EN_BIT = 0;
  localparam int unsigned DBW_CTL_MODE_BIT = 1;
  localparam int unsigned DBW_CTL_LOAD_BIT = 2;
  localparam int unsigned DBW_CTL_THR_LSB = 16;
  localparam int unsigned DBW_CTL_THR_MSB = 23;
  localparam logic [31:0] DBW_IBC_WMASK = 32'h00FF0003;
  localparam logic [31:0] DBW_DWC_WMASK = 32'h00FF0007;
  localparam logic [31:0] DBW_RWC_WMASK = 32'h00FF0003;

  // interrupt type register fields
  localparam int unsigned DBW_TYPE_CAUSE_LSB = 0;
  localparam int unsigned DBW_TYPE_THR_LSB = 8;
  localparam int unsigned DBW_TYPE_IDX_LSB = 16;
  localparam logic [31:0] DBW_TYPE_WMASK = 32'h0003FF07;

  // reset values
  localparam logic [31:0] DBW_CTL_RST = 32'h00000000;
  localparam logic [31:0] DBW_ADDR_RST = 32'h00000000;
  localparam logic [31:0] DBW_TYPE_RST = 32'h00000000;

  typedef enum logic [2:0] {
    DBW_CAUSE_NONE = 3'h0,
    DBW_CAUSE_INSTR = 3'h3,
    DBW_CAUSE_DATA = 3'h4,
    DBW_CAUSE_RES = 3'h5
  } dbw_cause_type;

  typedef enum logic [2:0] {
    DBW_KIND_INSTR = 3'b001,
    DBW_KIND_DATA = 3'b010,
    DBW_KIND_RES = 3'b100
  } dbw_kind_type;
endpackage

// ---- rtl/dbw_core_if.sv ----
/*
  carries one cycle of core pipeline activity to the match units.
  assumes all signals are on the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface dbw_core_if;
  logic [2:0] thread;
  logic pc_valid;
  logic [31:0] pc;
  logic ea_valid;
  logic ea_load;
  logic [31:0] ea;
  logic rid_valid;
  logic [31:0] rid;
  modport src (output thread, pc_valid, pc, ea_valid, ea_load, ea, rid_valid, rid);
  modport sink (input thread, pc_valid, pc, ea_valid, ea_load, ea, rid_valid, rid);
endinterface
`default_nettype wire

// ---- rtl/dbw_match.sv ----
/*
  one breakpoint or watchpoint comparator, kind chosen by parameter.
  assumes control and operands are registers of the same clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module dbw_match
  import dbw_pkg::*;
#(
  parameter dbw_kind_type KIND = DBW_KIND_INSTR
) (
  dbw_core_if.sink op,
  input wire logic [31:0] ctl,
  input wire logic [31:0] opa,
  input wire logic [31:0] opb,
  output logic hit
);
  logic [7:0] thr_en;
  logic a_ok;
  logic b_ok;

  always_comb begin
    thr_en = ctl[DBW_CTL_THR_MSB:DBW_CTL_THR_LSB];
    a_ok = 1'b0;
    b_ok = 1'b0;
    hit = 1'b0;
    if (KIND == DBW_KIND_INSTR) begin
      a_ok = (op.pc == opa);
      // equal or not equal
      hit = op.pc_valid && (ctl[DBW_CTL_MODE_BIT] ? !a_ok : a_ok);
    end else if (KIND == DBW_KIND_DATA) begin
      a_ok = (op.ea == opa);
      b_ok = (op.ea == opb);
      // and / or combine loads or stores
      hit = op.ea_valid && (ctl[DBW_CTL_LOAD_BIT] == op.ea_load) &&
            (ctl[DBW_CTL_MODE_BIT] ? (a_ok || b_ok) : (a_ok && b_ok));
    end else begin
      a_ok = ((op.rid & opa) == opb);
      hit = op.rid_valid && (ctl[DBW_CTL_MODE_BIT] ? !a_ok : a_ok);
    end
    // enable and per-thread gate
    hit = hit && ctl[DBW_CTL_EN_BIT] && thr_en[op.thread];
  end
endmodule
`default_nettype wire

// ---- rtl/dbw_cause.sv ----
/*
  picks the winning hit: instruction, then data, then resource, lowest index.
  assumes hit vectors are combinational from the match units.
*/
`timescale 1ns/1ps
`default_nettype none
module dbw_cause
  import dbw_pkg::*;
#(
  parameter int unsigned UNITS = DBW_UNITS
) (
  input wire logic [UNITS-1:0] ib_hit,
  input wire logic [UNITS-1:0] dw_hit,
  input wire logic [UNITS-1:0] rw_hit,
  output logic any_hit,
  output dbw_cause_type cause,
  output logic [1:0] index
);
  if (UNITS < 1 || UNITS > DBW_UNITS) begin : g_bad_units
    $error("dbw_cause: UNITS must be 1 to 4");
  end

  logic [UNITS-1:0] sel;

  always_comb begin
    any_hit = 1'b1;
    if (|ib_hit) begin
      cause = DBW_CAUSE_INSTR;
      sel = ib_hit;
    end else if (|dw_hit) begin
      cause = DBW_CAUSE_DATA;
      sel = dw_hit;
    end else if (|rw_hit) begin
      cause = DBW_CAUSE_RES;
      sel = rw_hit;
    end else begin
      any_hit = 1'b0;
      cause = DBW_CAUSE_NONE;
      sel = '0;
    end
    index = 2'h0;
    // lowest index wins
    for (int i = UNITS - 1; i >= 0; i--) begin
      if (sel[i]) begin
        index = 2'(i);
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/dbw_unit_sva.sv ----
/*
  port assertions of the breakpoint and watchpoint unit.
  assumes it is bound onto dbw_unit, one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dbw_unit_chk (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic issue_valid,
  input wire logic mem_valid,
  input wire logic res_valid,
  input wire logic debug_mode,
  input wire logic debug_irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  logic is_addr;
  assign is_addr = reg_addr[3:2] == 2'h0 && reg_addr[7:4] inside {4'h3, 4'h5, 4'h6, 4'h8, 4'h9};
  a_addr_reg_rw: assert property (reg_wr && is_addr ##1 !reg_wr ##1 reg_rd && reg_addr == $past(reg_addr, 2)
    |=> reg_rdata == $past(reg_wdata, 3)) else $error("address register lost its value");
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 32'h00000000)
    else $error("read data not zero outside read");
  a_ctl_reserved_zero: assert property (reg_rd && reg_addr[7:2] inside {6'h10, 6'h27}
    |=> reg_rdata[31:24] == 8'h00 && reg_rdata[15:2] == 14'h0000) else $error("reserved control bits set");
  a_data_ctl_reserved: assert property (reg_rd && reg_addr[7:2] == 6'h1C
    |=> reg_rdata[31:24] == 8'h00 && reg_rdata[15:3] == 13'h0000) else $error("reserved data control bits set");
  a_irq_needs_op: assert property (debug_irq |-> $past(issue_valid || mem_valid || res_valid))
    else $error("interrupt without core activity");
  a_mode_blocks_irq: assert property (debug_mode |=> !debug_irq)
    else $error("interrupt while in debug mode");
  a_quiet_after_reset: assert property ($fell(sys_rst) |-> !debug_irq [*2])
    else $error("interrupt right after reset");
  a_cause_code_legal: assert property (debug_irq && !reg_wr ##1 reg_rd && reg_addr == 8'h15
    |=> reg_rdata[2:0] inside {3'h3, 3'h4, 3'h5} && reg_rdata[31:18] == 14'h0000)
    else $error("bad cause code after interrupt");
endmodule
bind dbw_unit dbw_unit_chk u_dbw_unit_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .issue_valid(issue_valid),
  .mem_valid(mem_valid), .res_valid(res_valid), .debug_mode(debug_mode), .debug_irq(debug_irq));
`default_nettype wire

// ---- tb/dbw_core_model.sv ----
/*
  core pipeline model: one operation per call, one cycle long.
  assumes the caller sits just after a rising edge of clk.
*/
`timescale 1ns/1ps
`default_nettype none
module dbw_core_model (
  input wire logic clk,
  dbw_core_if.src op
);
  initial begin
    op.thread = 3'h0;
    op.pc_valid = 1'b0;
    op.ea_valid = 1'b0;
    op.ea_load = 1'b0;
    op.rid_valid = 1'b0;
    op.pc = 32'h00000000;
    op.ea = 32'h00000000;
    op.rid = 32'h00000000;
  end
  // kind 0 program counter, 1 memory, 2 resource
  task automatic drive(input int kind, input logic [2:0] thr, input logic ld, input logic [31:0] v);
    @(posedge clk);
    op.thread <= thr;
    op.pc_valid <= kind == 0;
    op.ea_valid <= kind == 1;
    op.rid_valid <= kind == 2;
    op.ea_load <= ld;
    op.pc <= v;
    op.ea <= v;
    op.rid <= v;
    @(posedge clk);
    op.pc_valid <= 1'b0;
    op.ea_valid <= 1'b0;
    op.rid_valid <= 1'b0;
    op.ea_load <= ~ld;
    op.pc <= ~v;
    op.ea <= ~v;
    op.rid <= ~v;
  endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/*
  testbench of the breakpoint and watchpoint unit.
  assumes the register port answers one cycle after the read strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic ref_clk, sys_rst, reg_wr, reg_rd, debug_mode, debug_irq;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  logic [7:0] bases[10] = '{8'h30, 8'h40, 8'h50, 8'h60, 8'h70, 8'h80, 8'h90, 8'h9C, 8'h15, 8'h16};
  logic [7:0] abase[5] = '{8'h30, 8'h50, 8'h60, 8'h80, 8'h90};
  logic [7:0] cadr[3] = '{8'h41, 8'h72, 8'h9F};
  logic [31:0] cmsk[3] = '{32'h00FF0003, 32'h00FF0007, 32'h00FF0003};
  dbw_core_if cif();
  dbw_core_model u_dbw_core_model (.clk(ref_clk), .op(cif.src));
  dbw_unit u_dbw_unit (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .issue_thread(cif.thread),
    .issue_valid(cif.pc_valid), .issue_pc(cif.pc), .mem_valid(cif.ea_valid), .mem_load(cif.ea_load),
    .mem_addr(cif.ea), .res_valid(cif.rid_valid), .res_id(cif.rid), .debug_mode(debug_mode),
    .debug_irq(debug_irq));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  task automatic core(input int k, input logic [2:0] t, input logic ld, input logic [31:0] v, input logic e);
    u_dbw_core_model.drive(k, t, ld, v);
    #1;
    chk(32'(debug_irq), {31'h0, e});
  endtask
  initial begin
    sys_rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h00000000;
    debug_mode = 1'b0;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    foreach (bases[i]) rd(bases[i], 32'h00000000);
    $display("test reset values done");
    foreach (abase[j]) for (int i = 0; i < 4; i++) begin
      wr(abase[j] + 8'(i), {24'hA5C3F0, abase[j] + 8'(i)});
      rd(abase[j] + 8'(i), {24'hA5C3F0, abase[j] + 8'(i)});
    end
    foreach (cadr[i]) begin
      wr(cadr[i], 32'hFFFFFFFF);
      rd(cadr[i], cmsk[i]);
      wr(cadr[i], 32'h00000000);
    end
    wr(8'h01, 32'hFFFFFFFF);
    rd(8'h01, 32'h00000000);
    $display("test register access done");
    wr(8'h32, 32'h00001000);
    wr(8'h42, 32'h00040001);
    core(0, 3'd2, 1'b0, 32'h00001000, 1'b1);
    rd(8'h15, 32'h00020203);
    core(0, 3'd1, 1'b0, 32'h00001000, 1'b0);
    core(0, 3'd2, 1'b0, 32'h00001004, 1'b0);
    wr(8'h42, 32'h00040003);
    core(0, 3'd2, 1'b0, 32'h00001004, 1'b1);
    core(0, 3'd2, 1'b0, 32'h00001000, 1'b0);
    @(posedge ref_clk);
    debug_mode <= 1'b1;
    core(0, 3'd2, 1'b0, 32'h00001004, 1'b0);
    @(posedge ref_clk);
    debug_mode <= 1'b0;
    wr(8'h42, 32'h00040002);
    core(0, 3'd2, 1'b0, 32'h00001004, 1'b0);
    $display("test instruction breakpoints done");
    wr(8'h51, 32'h00002000);
    wr(8'h61, 32'h00003000);
    wr(8'h71, 32'h00080001);
    core(1, 3'd3, 1'b0, 32'h00002000, 1'b0);
    wr(8'h71, 32'h00080003);
    core(1, 3'd3, 1'b0, 32'h00003000, 1'b1);
    rd(8'h15, 32'h00010304);
    rd(8'h16, 32'h00003000);
    core(1, 3'd3, 1'b1, 32'h00003000, 1'b0);
    wr(8'h71, 32'h00080007);
    core(1, 3'd3, 1'b1, 32'h00002000, 1'b1);
    core(1, 3'd3, 1'b0, 32'h00002000, 1'b0);
    $display("test data watchpoints done");
    wr(8'h80, 32'h0000FF00);
    wr(8'h90, 32'h00001200);
    wr(8'h9C, 32'h00010001);
    core(2, 3'd0, 1'b0, 32'h000012AB, 1'b1);
    rd(8'h15, 32'h00000005);
    rd(8'h16, 32'h000012AB);
    wr(8'h83, 32'h0000FF00);
    wr(8'h93, 32'h00001200);
    wr(8'h9F, 32'h00010003);
    wr(8'h9C, 32'h00010003);
    core(2, 3'd0, 1'b0, 32'h000012AB, 1'b0);
    core(2, 3'd0, 1'b0, 32'h000034AB, 1'b1);
    rd(8'h15, 32'h00000005);
    $display("test resource watchpoints done");
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(8'h9C, 32'h00000000);
    rd(8'h93, 32'h00000000);
    rd(8'h15, 32'h00000000);
    core(2, 3'd0, 1'b0, 32'h000034AB, 1'b0);
    $display("test mid-run reset done");
    stop_test();
  end
endmodule
`default_nettype wire
